// ===== src/timer_two_pkg.sv
// constants shared by the timer-two block: register offsets, field
// positions, reset values and the operating-mode encoding.
// assumes a byte-wide register port with byte addresses.
package timer_two_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int COUNT_W = 16;

  // register byte offsets
  localparam logic [ADDR_W-1:0] TIMER_EXTENDED_STATUS_OFS = 12'h411;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h418;
  localparam logic [ADDR_W-1:0] MODE_OFS = 12'h419;
  localparam logic [ADDR_W-1:0] CNT_LO_OFS = 12'h41A;
  localparam logic [ADDR_W-1:0] CNT_HI_OFS = 12'h41B;
  localparam logic [ADDR_W-1:0] RELOAD_LO_OFS = 12'h41C;
  localparam logic [ADDR_W-1:0] RELOAD_HI_OFS = 12'h41D;
  localparam logic [ADDR_W-1:0] CAPTURE_LO_OFS = 12'h41E;
  localparam logic [ADDR_W-1:0] CAPTURE_HI_OFS = 12'h41F;

  // timer_two_control fields
  localparam int OVF_FLAG_BIT = 7;
  localparam int EXT_FLAG_BIT = 6;
  localparam int RX_SEL_BIT = 5;
  localparam int TX_SEL_BIT = 4;
  localparam int EXT_EN_BIT = 3;
  localparam int RUN_BIT = 2;
  localparam int COUNTER_BIT = 1;
  localparam int CAPTURE_BIT = 0;
  // mode register fields
  localparam int OVF_IRQ_EN_BIT = 7;
  localparam int EXT_IRQ_EN_BIT = 6;
  localparam int DOWN_EN_BIT = 0;
  // timer_extended_status fields
  localparam int T1_TOGGLE_EN_BIT = 2;
  localparam int T0_TOGGLE_EN_BIT = 0;

  // reset values and the all-ones count top
  localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
  localparam logic [DATA_W-1:0] MODE_RST = 8'h00;
  localparam logic [DATA_W-1:0] TIMER_EXTENDED_STATUS_RST = 8'h00;
  localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_TOP = 16'hFFFF;
  localparam logic PIN_IDLE = 1'b1;

  typedef enum logic [2:0] {
    MODE_OFF = 3'h0,
    MODE_RELOAD_UP = 3'h1,
    MODE_RELOAD_UPDOWN = 3'h2,
    MODE_CAPTURE = 3'h3,
    MODE_BAUD = 3'h4
  } t2_mode_t;
endpackage

// ===== src/pin_filter.sv
// three-stage synchroniser for one external pin, with a filtered level
// and a one-cycle falling-edge pulse.
// assumes the pin is asynchronous to mclk_i and idles high.
module pin_filter (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic pin_i,
  output logic level_o,
  output logic fall_o
);
  import timer_two_pkg::*;

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;
  logic fall_r;
  wire agree = (s2_r == s3_r);

  // only the second stage reads s1_r; level moves once stages 2 and 3 agree
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s1_r <= PIN_IDLE;
      s2_r <= PIN_IDLE;
      s3_r <= PIN_IDLE;
      level_r <= PIN_IDLE;
      fall_r <= 1'b0;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (agree) begin
        level_r <= s3_r;
      end
      fall_r <= agree & level_r & ~s3_r;
    end
  end

  assign level_o = level_r;
  assign fall_o = fall_r;
endmodule

// ===== src/timer_two.sv
// timer two with capture, auto-reload, up/down and baud modes, plus the
// overflow toggle outputs of timers zero and one.
// assumes timer_tick_i is a one-cycle pulse of the prescaled timer clock
// and that timers zero and one hand over one-cycle overflow pulses.
//
// Strobed register access was chosen for this implementation.
module timer_two #(
  parameter int ADDR_W = timer_two_pkg::ADDR_W,
  parameter int COUNT_W = timer_two_pkg::COUNT_W
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [timer_two_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [timer_two_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic timer_tick_i,
  input wire logic timer_two_count_pin_i,
  input wire logic trigger_direction_pin_i,
  input wire logic t0_overflow_i,
  input wire logic t1_overflow_i,
  input wire logic t0_port_data_i,
  input wire logic t1_port_data_i,
  output logic t0_pin_o,
  output logic t0_pin_oe_o,
  output logic t1_pin_o,
  output logic t1_pin_oe_o,
  output logic uart_zero_rx_clk_o,
  output logic uart_zero_tx_clk_o,
  output logic timer_two_irq_o
);
  import timer_two_pkg::*;

  // the byte lanes and the all-ones compare are built for 16 bits only
  initial begin
    if (COUNT_W != 16 || ADDR_W < 12) begin
      $error("timer_two: COUNT_W must be 16 and ADDR_W at least 12");
    end
  end

  // merge one byte of a software write into a 16-bit word
  function automatic logic [15:0] put_byte(input logic [15:0] word, input logic hi,
                                           input logic [7:0] b);
    put_byte = hi ? {b, word[7:0]} : {word[15:8], b};
  endfunction

  logic [5:0] ctl_r;
  logic timer_two_overflow_flag_r;
  logic timer_two_external_flag_r;
  logic [DATA_W-1:0] mode_r;
  logic [DATA_W-1:0] timer_extended_status_r;
  logic [15:0] cnt_r;
  logic [15:0] reload_r;
  logic [15:0] capture_r;
  logic [DATA_W-1:0] rdata_r;
  logic t0_tog_r;
  logic t1_tog_r;
  logic t0_pin_r;
  logic t1_pin_r;
  logic rx_clk_r;
  logic tx_clk_r;
  logic irq_r;
  logic [15:0] cnt_nxt;
  logic ovf_flag_nxt;
  logic ext_flag_nxt;
  logic count_fall;
  logic trig_level;
  logic trig_fall;

  // external pins pass the three-stage filter
  pin_filter count_pin_sync (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(timer_two_count_pin_i),
    .level_o(),
    .fall_o(count_fall)
  );

  pin_filter trigger_pin_sync (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(trigger_direction_pin_i),
    .level_o(trig_level),
    .fall_o(trig_fall)
  );

  // register decode
  wire wr_ctrl = reg_wr_i && reg_addr_i == CTRL_OFS;
  wire wr_mode = reg_wr_i && reg_addr_i == MODE_OFS;
  wire wr_timer_extended_status = reg_wr_i && reg_addr_i == TIMER_EXTENDED_STATUS_OFS;
  wire wr_cnt_lo = reg_wr_i && reg_addr_i == CNT_LO_OFS;
  wire wr_cnt_hi = reg_wr_i && reg_addr_i == CNT_HI_OFS;
  wire wr_rld_lo = reg_wr_i && reg_addr_i == RELOAD_LO_OFS;
  wire wr_rld_hi = reg_wr_i && reg_addr_i == RELOAD_HI_OFS;
  wire cnt_wr = wr_cnt_lo | wr_cnt_hi;

  // control fields
  wire rx_sel = ctl_r[RX_SEL_BIT];
  wire tx_sel = ctl_r[TX_SEL_BIT];
  wire ext_en = ctl_r[EXT_EN_BIT];
  wire run = ctl_r[RUN_BIT];
  wire counter_sel = ctl_r[COUNTER_BIT];
  wire capture_sel = ctl_r[CAPTURE_BIT];
  wire down_en = mode_r[DOWN_EN_BIT];
  wire baud = rx_sel | tx_sel;

  // one mode at a time; baud selection outranks capture and reload
  t2_mode_t mode;
  assign mode = !run ? MODE_OFF :
                baud ? MODE_BAUD :
                capture_sel ? MODE_CAPTURE :
                down_en ? MODE_RELOAD_UPDOWN : MODE_RELOAD_UP;

  // baud mode always runs on the timer tick, whatever the counter select
  wire step = (mode != MODE_OFF) &&
              ((counter_sel && !baud) ? count_fall : timer_tick_i);
  wire count_down = (mode == MODE_RELOAD_UPDOWN) && !trig_level;
  wire ovf = step && !count_down && cnt_r == COUNT_TOP;
  wire unf = step && count_down && cnt_r == reload_r;
  wire roll = ovf | unf;
  // in up/down mode the trigger pin is the direction, not an event
  wire trig = trig_fall && ext_en && mode != MODE_OFF && mode != MODE_RELOAD_UPDOWN;
  wire trig_reload = trig && mode == MODE_RELOAD_UP;
  wire trig_capture = trig && mode == MODE_CAPTURE;

  // count update; a software write wins over the count step
  always_comb begin
    cnt_nxt = cnt_r;
    if (wr_cnt_lo || wr_cnt_hi) begin
      cnt_nxt = put_byte(cnt_r, wr_cnt_hi, reg_wdata_i);
    end else if (ovf) begin
      // plain 16-bit wrap in capture mode, reload otherwise
      cnt_nxt = (mode == MODE_CAPTURE) ? COUNT_RST : reload_r;
    end else if (unf) begin
      cnt_nxt = COUNT_TOP;
    end else if (trig_reload) begin
      cnt_nxt = reload_r;
    end else if (step) begin
      cnt_nxt = count_down ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
    end
  end

  // flags: hardware set beats a software clear in the same cycle
  wire ovf_base = wr_ctrl ? reg_wdata_i[OVF_FLAG_BIT] : timer_two_overflow_flag_r;
  wire ext_base = wr_ctrl ? reg_wdata_i[EXT_FLAG_BIT] : timer_two_external_flag_r;
  assign ovf_flag_nxt = ovf_base | (roll && !baud);
  assign ext_flag_nxt = (mode == MODE_RELOAD_UPDOWN) ?
                        ext_base ^ roll :
                        ext_base | trig;

  // flags and control
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctl_r <= CTRL_RST[5:0];
      timer_two_overflow_flag_r <= CTRL_RST[OVF_FLAG_BIT];
      timer_two_external_flag_r <= CTRL_RST[EXT_FLAG_BIT];
      mode_r <= MODE_RST;
      timer_extended_status_r <= TIMER_EXTENDED_STATUS_RST;
    end else begin
      timer_two_overflow_flag_r <= ovf_flag_nxt;
      timer_two_external_flag_r <= ext_flag_nxt;
      if (wr_ctrl) begin
        ctl_r <= reg_wdata_i[5:0];
      end
      if (wr_mode) begin
        mode_r <= reg_wdata_i;
      end
      if (wr_timer_extended_status) begin
        timer_extended_status_r <= reg_wdata_i;
      end
    end
  end

  // count, reload and capture words
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_r <= COUNT_RST;
      reload_r <= COUNT_RST;
      capture_r <= COUNT_RST;
    end else begin
      cnt_r <= cnt_nxt;
      if (wr_rld_lo || wr_rld_hi) begin
        reload_r <= put_byte(reload_r, wr_rld_hi, reg_wdata_i);
      end
      if (trig_capture) begin
        capture_r <= cnt_r;
      end
    end
  end

  // read mux; unmapped addresses read zero
  logic [DATA_W-1:0] rd_mux;
  assign rd_mux =
    (reg_addr_i == CTRL_OFS) ?
      {timer_two_overflow_flag_r, timer_two_external_flag_r, ctl_r} :
    (reg_addr_i == MODE_OFS) ? mode_r :
    (reg_addr_i == TIMER_EXTENDED_STATUS_OFS) ? timer_extended_status_r :
    (reg_addr_i == CNT_LO_OFS) ? cnt_r[7:0] :
    (reg_addr_i == CNT_HI_OFS) ? cnt_r[15:8] :
    (reg_addr_i == RELOAD_LO_OFS) ? reload_r[7:0] :
    (reg_addr_i == RELOAD_HI_OFS) ? reload_r[15:8] :
    (reg_addr_i == CAPTURE_LO_OFS) ? capture_r[7:0] :
    (reg_addr_i == CAPTURE_HI_OFS) ? capture_r[15:8] : 8'h00;

  // interrupt request: the external flag is a count bit in up/down mode
  wire irq_nxt = (timer_two_overflow_flag_r && mode_r[OVF_IRQ_EN_BIT]) ||
                 (timer_two_external_flag_r && mode_r[EXT_IRQ_EN_BIT] &&
                  mode != MODE_RELOAD_UPDOWN);

  // output flops: read data, baud clocks, toggles, pins, interrupt
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_r <= 8'h00;
      rx_clk_r <= 1'b0;
      tx_clk_r <= 1'b0;
      t0_tog_r <= 1'b0;
      t1_tog_r <= 1'b0;
      t0_pin_r <= 1'b0;
      t1_pin_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      rdata_r <= reg_rd_i ? rd_mux : 8'h00;
      rx_clk_r <= rx_sel ? (ovf && baud) : t1_overflow_i;
      tx_clk_r <= tx_sel ? (ovf && baud) : t1_overflow_i;
      t0_tog_r <= t0_tog_r ^ t0_overflow_i;
      t1_tog_r <= t1_tog_r ^ t1_overflow_i;
      t0_pin_r <= timer_extended_status_r[T0_TOGGLE_EN_BIT] ? t0_tog_r : t0_port_data_i;
      t1_pin_r <= timer_extended_status_r[T1_TOGGLE_EN_BIT] ? t1_tog_r : t1_port_data_i;
      irq_r <= irq_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign uart_zero_rx_clk_o = rx_clk_r;
  assign uart_zero_tx_clk_o = tx_clk_r;
  // the pin is an input for counting unless the toggle owns it
  assign t0_pin_o = t0_pin_r;
  assign t0_pin_oe_o = timer_extended_status_r[T0_TOGGLE_EN_BIT];
  assign t1_pin_o = t1_pin_r;
  assign t1_pin_oe_o = timer_extended_status_r[T1_TOGGLE_EN_BIT];
  assign timer_two_irq_o = irq_r;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);

  overflow_flag_a: assert property (
    roll && !baud |=> timer_two_overflow_flag_r)
    else $error("overflow flag not set on roll");

  ext_flag_set_a: assert property (
    trig |=> timer_two_external_flag_r)
    else $error("external flag not set on trigger edge");

  rx_clock_sel_a: assert property (
    ovf && rx_sel && !wr_ctrl |=> uart_zero_rx_clk_o)
    else $error("rx clock missed timer two overflow");

  stopped_hold_a: assert property (
    mode == MODE_OFF && !cnt_wr |=> cnt_r == $past(cnt_r))
    else $error("stopped count changed");

  capture_copy_a: assert property (
    trig_capture |=> capture_r == $past(cnt_r))
    else $error("capture did not take the count");

  reload_on_ovf_a: assert property (
    ovf && mode == MODE_RELOAD_UP && !cnt_wr |=> cnt_r == $past(reload_r))
    else $error("overflow did not reload count");

  down_step_a: assert property (
    step && count_down && !unf && !cnt_wr |=> cnt_r == $past(cnt_r) - 16'h0001)
    else $error("down count step wrong");

  underflow_load_a: assert property (
    unf && !cnt_wr |=> cnt_r == COUNT_TOP && timer_two_overflow_flag_r)
    else $error("underflow did not load all ones");

  irq_from_flag_a: assert property (
    timer_two_overflow_flag_r && mode_r[OVF_IRQ_EN_BIT] |=> timer_two_irq_o)
    else $error("enabled overflow flag raised no interrupt");

  toggle_flip_a: assert property (
    t0_overflow_i |=> t0_tog_r != $past(t0_tog_r))
    else $error("timer zero toggle did not flip");

  flag_sticky_a: assert property (
    timer_two_overflow_flag_r && !wr_ctrl |=> timer_two_overflow_flag_r)
    else $error("overflow flag dropped without a write");

  capture_wrap_a: assert property (
    ovf && mode == MODE_CAPTURE && !cnt_wr |=> cnt_r == COUNT_RST)
    else $error("capture mode overflow did not wrap to zero");

  trig_reload_a: assert property (
    trig_reload && !cnt_wr |=> cnt_r == $past(reload_r))
    else $error("trigger edge did not reload count");

  up_step_a: assert property (
    step && !count_down && !ovf && !trig_reload && !cnt_wr |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("up count step wrong");

  count_src_a: assert property (
    counter_sel && !baud && !count_fall && !trig_reload && !cnt_wr |=> cnt_r == $past(cnt_r))
    else $error("counter mode stepped without a pin edge");

  ext_toggle_a: assert property (
    mode == MODE_RELOAD_UPDOWN && roll && !wr_ctrl |=>
      timer_two_external_flag_r != $past(timer_two_external_flag_r))
    else $error("external flag did not toggle on roll");

  no_ext_irq_a: assert property (
    mode == MODE_RELOAD_UPDOWN && !mode_r[OVF_IRQ_EN_BIT] |=> !timer_two_irq_o)
    else $error("up/down mode raised an interrupt from the external flag");

  baud_reload_a: assert property (
    ovf && mode == MODE_BAUD && !cnt_wr |=> cnt_r == $past(reload_r))
    else $error("baud mode overflow did not reload count");

  baud_no_flag_a: assert property (
    ovf && baud && !wr_ctrl && !timer_two_overflow_flag_r |=> !timer_two_overflow_flag_r)
    else $error("baud mode overflow set the overflow flag");

  tx_clock_sel_a: assert property (
    ovf && tx_sel |=> uart_zero_tx_clk_o)
    else $error("tx clock missed timer two overflow");

  port_pass_a: assert property (
    !timer_extended_status_r[T0_TOGGLE_EN_BIT] |=> t0_pin_o == $past(t0_port_data_i))
    else $error("timer zero pin did not follow port data");

  toggle_drive_a: assert property (
    timer_extended_status_r[T1_TOGGLE_EN_BIT] |=> t1_pin_o == $past(t1_tog_r))
    else $error("timer one pin did not follow its toggle");
endmodule

// ===== sim/ext_pins.sv
// model of the external pins: event count pin and trigger/direction pin.
// assumes one bench process calls the tasks; both pins have pull-ups.
module ext_pins (
  input wire logic mclk_i,
  output logic count_pin_o,
  output logic trig_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // pulled-up pins idle high
  initial begin
    count_pin_o = 1'b1;
    trig_pin_o = 1'b1;
  end

  // low pulse held six cycles so it outlives the synchroniser
  task automatic pulse_count();
    @(posedge mclk_i) count_pin_o <= 1'b0;
    repeat (6) @(posedge mclk_i);
    count_pin_o <= 1'b1;
    repeat (6) @(posedge mclk_i);
  endtask

  // level holds until the next call, so it doubles as the direction
  task automatic set_trig(input logic lvl);
    @(posedge mclk_i) trig_pin_o <= lvl;
    repeat (6) @(posedge mclk_i);
  endtask
endmodule

// ===== sim/timer_two_tb.sv
// self-checking bench for timer_two: registers, all timer modes, toggle pins.
// assumes ext_pins drives the two external pins; ticks come from the bench.
`define CHK(act, exp) begin check_count++; if ((act) !== (exp)) begin n_mismatch++; \
  $display("ERROR %0t: got %h expected %h", $time, act, exp); end end
module timer_two_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import timer_two_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr = 12'h000;
  logic [DATA_W-1:0] wdata = 8'h00;
  logic [DATA_W-1:0] rdata;
  logic wr_s = 1'b0, rd_s = 1'b0, tick = 1'b0, t0_ovf = 1'b0, t1_ovf = 1'b0;
  logic port0 = 1'b1, port1 = 1'b1;
  logic cnt_pin, trig_pin, t0_pin, t0_oe, t1_pin, t1_oe, rx_clk, tx_clk, irq;
  int n_mismatch = 0;
  int check_count = 0;

  // 40 MHz clock
  always #12.5 mclk = ~mclk;

  timer_two DUT (.mclk_i(mclk), .sys_rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .timer_tick_i(tick),
    .timer_two_count_pin_i(cnt_pin), .trigger_direction_pin_i(trig_pin),
    .t0_overflow_i(t0_ovf), .t1_overflow_i(t1_ovf), .t0_port_data_i(port0),
    .t1_port_data_i(port1), .t0_pin_o(t0_pin), .t0_pin_oe_o(t0_oe), .t1_pin_o(t1_pin),
    .t1_pin_oe_o(t1_oe), .uart_zero_rx_clk_o(rx_clk), .uart_zero_tx_clk_o(tx_clk),
    .timer_two_irq_o(irq));

  ext_pins pins (.mclk_i(mclk), .count_pin_o(cnt_pin), .trig_pin_o(trig_pin));

  task automatic results();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // bus cycles: strobes one cycle, read data sampled in the following cycle
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge mclk);
    wr_s <= 1'b0;
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge mclk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk);
    rd_s <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  // 16-bit values travel as two independent bytes, low first
  task automatic wr16(input logic [ADDR_W-1:0] a, input logic [COUNT_W-1:0] v);
    wr(a, v[7:0]);
    wr(a + 12'h001, v[15:8]);
  endtask
  task automatic rd16_chk(input logic [ADDR_W-1:0] a, input logic [COUNT_W-1:0] e);
    rd_chk(a, e[7:0]);
    rd_chk(a + 12'h001, e[15:8]);
  endtask
  task automatic tick1();
    @(posedge mclk) tick <= 1'b1;
    @(posedge mclk) tick <= 1'b0;
  endtask
  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask
  // bounded wait for a pulse on both uart clocks; a miss ends the run
  task automatic wait_uart();
    int k;
    for (k = 0; k < 6; k++) begin
      #1;
      if (rx_clk === 1'b1 && tx_clk === 1'b1) break;
      @(posedge mclk);
    end
    check_count++;
    if (k == 6) begin
      n_mismatch++;
      $display("ERROR %0t: uart clock pulse missing", $time);
      results();
    end
  endtask

  task automatic s_regs();
    rd_chk(CTRL_OFS, 8'h00);
    rd_chk(MODE_OFS, 8'h00);
    rd_chk(TIMER_EXTENDED_STATUS_OFS, 8'h00);
    rd_chk(12'h400, 8'h00);
    wr(CAPTURE_LO_OFS, 8'h5A);
    rd_chk(CAPTURE_LO_OFS, 8'h00);
  endtask

  task automatic s_reload_up();
    wr16(RELOAD_LO_OFS, 16'hFFFE);
    wr16(CNT_LO_OFS, 16'hFFFF);
    wr(MODE_OFS, 8'h80);
    wr(CTRL_OFS, 8'h04);
    tick1();
    rd16_chk(CNT_LO_OFS, 16'hFFFE);
    rd_chk(CTRL_OFS, 8'h84);
    `CHK(irq, 1'b1)
    wr(CTRL_OFS, 8'h04);
    settle();
    `CHK(irq, 1'b0)
    wr(CTRL_OFS, 8'h00);
    tick1();
    rd16_chk(CNT_LO_OFS, 16'hFFFE);
    wr16(CNT_LO_OFS, 16'h1234);
    wr(CTRL_OFS, 8'h0C);
    pins.set_trig(1'b0);
    pins.set_trig(1'b1);
    rd16_chk(CNT_LO_OFS, 16'hFFFE);
    rd_chk(CTRL_OFS, 8'h4C);
  endtask

  task automatic s_capture();
    wr(CTRL_OFS, 8'h00);
    wr(MODE_OFS, 8'h40);
    wr16(CNT_LO_OFS, 16'hABCD);
    wr(CTRL_OFS, 8'h0D);
    pins.set_trig(1'b0);
    pins.set_trig(1'b1);
    rd16_chk(CAPTURE_LO_OFS, 16'hABCD);
    rd_chk(CTRL_OFS, 8'h4D);
    `CHK(irq, 1'b1)
    wr(CTRL_OFS, 8'h05);
    wr16(CNT_LO_OFS, 16'hFFFF);
    tick1();
    rd16_chk(CNT_LO_OFS, 16'h0000);
    rd_chk(CTRL_OFS, 8'h85);
  endtask

  // direction from the trigger pin; underflow compares with the reload value
  task automatic s_updown();
    wr(CTRL_OFS, 8'h00);
    wr(MODE_OFS, 8'h41);
    wr16(RELOAD_LO_OFS, 16'h0010);
    wr16(CNT_LO_OFS, 16'h0011);
    pins.set_trig(1'b0);
    wr(CTRL_OFS, 8'h04);
    tick1();
    rd16_chk(CNT_LO_OFS, 16'h0010);
    tick1();
    rd16_chk(CNT_LO_OFS, 16'hFFFF);
    rd_chk(CTRL_OFS, 8'hC4);
    wr(CTRL_OFS, 8'h44);
    settle();
    `CHK(irq, 1'b0)
    pins.set_trig(1'b1);
    tick1();
    rd16_chk(CNT_LO_OFS, 16'h0010);
    rd_chk(CTRL_OFS, 8'h84);
  endtask

  // ticks must be ignored while counting pin events
  task automatic s_counter();
    wr(CTRL_OFS, 8'h00);
    wr(MODE_OFS, 8'h00);
    wr16(CNT_LO_OFS, 16'h0000);
    wr(CTRL_OFS, 8'h06);
    tick1();
    repeat (3) pins.pulse_count();
    rd16_chk(CNT_LO_OFS, 16'h0003);
  endtask

  task automatic s_baud();
    wr(CTRL_OFS, 8'h00);
    wr16(RELOAD_LO_OFS, 16'hFFFF);
    wr16(CNT_LO_OFS, 16'hFFFF);
    wr(CTRL_OFS, 8'h34);
    tick1();
    wait_uart();
    rd_chk(CTRL_OFS, 8'h34);
  endtask

  task automatic s_toggle();
    wr(CTRL_OFS, 8'h00);
    // port data passes to both pins while the toggles are off, both levels
    for (int v = 1; v >= 0; v--) begin
      @(posedge mclk) port0 <= v[0];
      port1 <= v[0];
      settle();
      `CHK({t0_pin, t0_oe, t1_pin, t1_oe}, {v[0], 1'b0, v[0], 1'b0})
    end
    wr(TIMER_EXTENDED_STATUS_OFS, 8'h05);
    @(posedge mclk) t0_ovf <= 1'b1;
    t1_ovf <= 1'b1;
    @(posedge mclk) t0_ovf <= 1'b0;
    t1_ovf <= 1'b0;
    wait_uart();
    settle();
    `CHK({t0_pin, t0_oe, t1_pin, t1_oe}, 4'b1111)
  endtask

  // reset for 8 cycles, then the scenarios in turn
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    s_regs();
    s_reload_up();
    s_capture();
    s_updown();
    s_counter();
    s_baud();
    s_toggle();
    results();
  end
endmodule
